// >>> pcg_consts.svh
// Register offsets, reset values and read defaults of the port C block
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

`define PCG_ADDR_W          3
`define PCG_DATA_W          8

`define PCG_OFS_DIRECTION   3'h0
`define PCG_OFS_LATCH       3'h1
`define PCG_OFS_VIEW        3'h2
`define PCG_OFS_PULLUP      3'h3
`define PCG_OFS_OTYPE       3'h4

`define PCG_RST_DIRECTION   8'h00
`define PCG_RST_LATCH       8'h00
`define PCG_RST_PULLUP      8'h00
`define PCG_RST_OTYPE       8'h00

// Value returned for the write-only direction register
`define PCG_DIR_READ_VALUE  8'h00
// Value returned for an unmapped address or an idle read bus
`define PCG_IDLE_READ_VALUE 8'h00

`define PCG_BIT_CH0_TX      0
`define PCG_BIT_CH0_RX      1
`define PCG_BIT_CH0_CLK     2
`define PCG_BIT_CH1_TX      3
`define PCG_BIT_CH1_RX      4
`define PCG_BIT_CH1_CLK     5

`define PCG_SYNC_STAGES     2

`endif

// >>> pcg_pkg.sv
// Types shared by the port C block
package pcg_pkg;

    typedef enum logic [1:0] {
        PCG_FN_GP_IN   = 2'b00,
        PCG_FN_GP_OUT  = 2'b01,
        PCG_FN_PER_OUT = 2'b10,
        PCG_FN_PER_IN  = 2'b11
    } pcg_fn_t;

endpackage

// >>> pcg_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module pcg_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r   <= '0;
            stable_r <= '0;
        end else begin
            meta_r   <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule

// >>> pcg_pin_mux.sv
// Per-pin function select, drive and pull-up decision
`timescale 1ns/1ps
module pcg_pin_mux
    import pcg_pkg::*;
(
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic otype,
    input  wire logic pull_sel,
    input  wire logic per_out_en,
    input  wire logic per_out_val,
    input  wire logic per_in_en,
    output pcg_fn_t   fn,
    output logic      drive_val,
    output logic      drive_en,
    output logic      pull_en
);

    always_comb begin
        // Peripheral input, then peripheral output, then direction bit
        if (per_in_en) begin
            fn = PCG_FN_PER_IN;
        end else if (per_out_en) begin
            fn = PCG_FN_PER_OUT;
        end else if (dir) begin
            fn = PCG_FN_GP_OUT;
        end else begin
            fn = PCG_FN_GP_IN;
        end
        drive_val = (fn == PCG_FN_PER_OUT) ? per_out_val : latch;
        // Open drain only pulls low; high side stays off
        drive_en  = ((fn == PCG_FN_GP_OUT) || (fn == PCG_FN_PER_OUT))
                    && (!otype || !drive_val);
        pull_en   = (fn == PCG_FN_GP_IN) && pull_sel;
    end

endmodule

// >>> pcg_port.sv
// Eight-bit general purpose port C with serial and interrupt pin sharing
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pcg_consts.svh"
module pcg_port
    import pcg_pkg::*;
#(
    parameter int PORT_W = `PCG_DATA_W
) (
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    // Register port
    input  wire logic [`PCG_ADDR_W-1:0]  reg_addr,
    input  wire logic [PORT_W-1:0]       reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [PORT_W-1:0]       reg_rdata,
    // Serial channel one controls
    input  wire logic                    ch1_external_clock_select,
    input  wire logic                    ch1_sync_mode,
    input  wire logic                    ch1_clock_output_enable,
    input  wire logic                    ch1_receive_enable,
    input  wire logic                    ch1_transmit_enable,
    input  wire logic                    serial_ch1_clock_out,
    input  wire logic                    serial_ch1_transmit,
    output logic                         serial_ch1_clock_in,
    output logic                         serial_ch1_receive,
    // Serial channel zero controls
    input  wire logic                    ch0_external_clock_select,
    input  wire logic                    ch0_sync_mode,
    input  wire logic                    ch0_clock_output_enable,
    input  wire logic                    ch0_receive_enable,
    input  wire logic                    ch0_transmit_enable,
    input  wire logic                    serial_ch0_clock_out,
    input  wire logic                    serial_ch0_transmit,
    output logic                         serial_ch0_clock_in,
    output logic                         serial_ch0_receive,
    // Interrupt inputs fed from bits 2 and 5
    output logic                         external_interrupt_a,
    output logic                         external_interrupt_b,
    // Pads
    input  wire logic [PORT_W-1:0]       pin_in,
    output logic      [PORT_W-1:0]       pin_out,
    output logic      [PORT_W-1:0]       pin_oe,
    output logic      [PORT_W-1:0]       pin_pullup_en
);

    // Clock pin decode: {clock output, clock input}
    function automatic logic [1:0] clock_pin_fn(
        input logic ext_sel,
        input logic sync_mode,
        input logic out_en
    );
        logic clk_out;
        logic clk_in;
        clk_out = !ext_sel && (sync_mode || out_en);
        clk_in  = ext_sel;
        return {clk_out, clk_in};
    endfunction

    // Address match for a register access
    function automatic logic hit(
        input logic                   strobe,
        input logic [`PCG_ADDR_W-1:0] addr,
        input logic [`PCG_ADDR_W-1:0] ofs
    );
        return strobe && (addr == ofs);
    endfunction

    //------------------------------------------------------------
    // Configuration registers
    //------------------------------------------------------------
    logic [PORT_W-1:0] pin_direction_r;
    logic [PORT_W-1:0] pin_direction_nxt;
    logic [PORT_W-1:0] output_latch_r;
    logic [PORT_W-1:0] output_latch_nxt;
    logic [PORT_W-1:0] pullup_select_r;
    logic [PORT_W-1:0] pullup_select_nxt;
    logic [PORT_W-1:0] output_type_select_r;
    logic [PORT_W-1:0] output_type_select_nxt;

    always_comb begin
        pin_direction_nxt      = pin_direction_r;
        output_latch_nxt       = output_latch_r;
        pullup_select_nxt      = pullup_select_r;
        output_type_select_nxt = output_type_select_r;
        if (hit(reg_wr, reg_addr, `PCG_OFS_DIRECTION)) begin
            pin_direction_nxt = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, `PCG_OFS_LATCH)) begin
            output_latch_nxt = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, `PCG_OFS_PULLUP)) begin
            pullup_select_nxt = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, `PCG_OFS_OTYPE)) begin
            output_type_select_nxt = reg_wdata;
        end
        // Writes to the view offset fall through untouched
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_direction_r      <= `PCG_RST_DIRECTION;
            output_latch_r       <= `PCG_RST_LATCH;
            pullup_select_r      <= `PCG_RST_PULLUP;
            output_type_select_r <= `PCG_RST_OTYPE;
        end else begin
            pin_direction_r      <= pin_direction_nxt;
            output_latch_r       <= output_latch_nxt;
            pullup_select_r      <= pullup_select_nxt;
            output_type_select_r <= output_type_select_nxt;
        end
    end

    //------------------------------------------------------------
    // Pin level synchronisation
    //------------------------------------------------------------
    logic [PORT_W-1:0] pin_sync;

    pcg_sync #(
        .WIDTH    (PORT_W)
    ) u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    //------------------------------------------------------------
    // Peripheral claims on each pin
    //------------------------------------------------------------
    logic [PORT_W-1:0] per_out_en;
    logic [PORT_W-1:0] per_out_val;
    logic [PORT_W-1:0] per_in_en;
    logic [1:0]        ch1_clk_fn;
    logic [1:0]        ch0_clk_fn;

    always_comb begin
        per_out_en  = '0;
        per_out_val = '0;
        per_in_en   = '0;
        // Bits 7 and 6 stay plain general purpose
        ch1_clk_fn = clock_pin_fn(ch1_external_clock_select,
                                  ch1_sync_mode,
                                  ch1_clock_output_enable);
        ch0_clk_fn = clock_pin_fn(ch0_external_clock_select,
                                  ch0_sync_mode,
                                  ch0_clock_output_enable);
        // Channel one clock pin
        per_out_en[`PCG_BIT_CH1_CLK]  = ch1_clk_fn[1];
        per_out_val[`PCG_BIT_CH1_CLK] = serial_ch1_clock_out;
        per_in_en[`PCG_BIT_CH1_CLK]   = ch1_clk_fn[0];
        // Channel one receive and transmit
        per_in_en[`PCG_BIT_CH1_RX]    = ch1_receive_enable;
        per_out_en[`PCG_BIT_CH1_TX]   = ch1_transmit_enable;
        per_out_val[`PCG_BIT_CH1_TX]  = serial_ch1_transmit;
        // Channel zero clock pin
        per_out_en[`PCG_BIT_CH0_CLK]  = ch0_clk_fn[1];
        per_out_val[`PCG_BIT_CH0_CLK] = serial_ch0_clock_out;
        per_in_en[`PCG_BIT_CH0_CLK]   = ch0_clk_fn[0];
        // Channel zero receive and transmit
        per_in_en[`PCG_BIT_CH0_RX]    = ch0_receive_enable;
        per_out_en[`PCG_BIT_CH0_TX]   = ch0_transmit_enable;
        per_out_val[`PCG_BIT_CH0_TX]  = serial_ch0_transmit;
    end

    //------------------------------------------------------------
    // Per-pin function and drive
    //------------------------------------------------------------
    pcg_fn_t           pin_fn [PORT_W];
    logic [PORT_W-1:0] drive_val;
    logic [PORT_W-1:0] drive_en;
    logic [PORT_W-1:0] pull_en;

    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        pcg_pin_mux u_mux (
            .dir         (pin_direction_r[i]),
            .latch       (output_latch_r[i]),
            .otype       (output_type_select_r[i]),
            .pull_sel    (pullup_select_r[i]),
            .per_out_en  (per_out_en[i]),
            .per_out_val (per_out_val[i]),
            .per_in_en   (per_in_en[i]),
            .fn          (pin_fn[i]),
            .drive_val   (drive_val[i]),
            .drive_en    (drive_en[i]),
            .pull_en     (pull_en[i])
        );
    end

    //------------------------------------------------------------
    // Registered pad outputs
    //------------------------------------------------------------
    logic [PORT_W-1:0] pin_out_r;
    logic [PORT_W-1:0] pin_out_nxt;
    logic [PORT_W-1:0] pin_oe_r;
    logic [PORT_W-1:0] pin_oe_nxt;
    logic [PORT_W-1:0] pin_pullup_r;
    logic [PORT_W-1:0] pin_pullup_nxt;

    always_comb begin
        pin_out_nxt    = drive_val;
        pin_oe_nxt     = drive_en;
        pin_pullup_nxt = pull_en;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_out_r    <= '0;
            pin_oe_r     <= '0;
            pin_pullup_r <= '0;
        end else begin
            pin_out_r    <= pin_out_nxt;
            pin_oe_r     <= pin_oe_nxt;
            pin_pullup_r <= pin_pullup_nxt;
        end
    end

    assign pin_out       = pin_out_r;
    assign pin_oe        = pin_oe_r;
    assign pin_pullup_en = pin_pullup_r;

    //------------------------------------------------------------
    // Levels handed to the serial channels and interrupt inputs
    //------------------------------------------------------------
    logic ch1_clk_in_r;
    logic ch1_clk_in_nxt;
    logic ch1_rx_r;
    logic ch1_rx_nxt;
    logic ch0_clk_in_r;
    logic ch0_clk_in_nxt;
    logic ch0_rx_r;
    logic ch0_rx_nxt;
    logic irq_a_r;
    logic irq_a_nxt;
    logic irq_b_r;
    logic irq_b_nxt;

    always_comb begin
        ch1_clk_in_nxt = pin_sync[`PCG_BIT_CH1_CLK];
        ch1_rx_nxt     = pin_sync[`PCG_BIT_CH1_RX];
        ch0_clk_in_nxt = pin_sync[`PCG_BIT_CH0_CLK];
        ch0_rx_nxt     = pin_sync[`PCG_BIT_CH0_RX];
        // Interrupt inputs always see the pad level
        irq_a_nxt      = pin_sync[`PCG_BIT_CH0_CLK];
        irq_b_nxt      = pin_sync[`PCG_BIT_CH1_CLK];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ch1_clk_in_r <= 1'b0;
            ch1_rx_r     <= 1'b0;
            ch0_clk_in_r <= 1'b0;
            ch0_rx_r     <= 1'b0;
            irq_a_r      <= 1'b0;
            irq_b_r      <= 1'b0;
        end else begin
            ch1_clk_in_r <= ch1_clk_in_nxt;
            ch1_rx_r     <= ch1_rx_nxt;
            ch0_clk_in_r <= ch0_clk_in_nxt;
            ch0_rx_r     <= ch0_rx_nxt;
            irq_a_r      <= irq_a_nxt;
            irq_b_r      <= irq_b_nxt;
        end
    end

    assign serial_ch1_clock_in  = ch1_clk_in_r;
    assign serial_ch1_receive   = ch1_rx_r;
    assign serial_ch0_clock_in  = ch0_clk_in_r;
    assign serial_ch0_receive   = ch0_rx_r;
    assign external_interrupt_a = irq_a_r;
    assign external_interrupt_b = irq_b_r;

    //------------------------------------------------------------
    // Register read path
    //------------------------------------------------------------
    logic [PORT_W-1:0] pin_level_view;
    logic [PORT_W-1:0] rdata_r;
    logic [PORT_W-1:0] rdata_nxt;

    always_comb begin
        // Latch where output, synchronised pad where input
        pin_level_view = (pin_direction_r & output_latch_r)
                       | (~pin_direction_r & pin_sync);
        rdata_nxt = `PCG_IDLE_READ_VALUE;
        if (reg_rd) begin
            unique case (reg_addr)
                `PCG_OFS_DIRECTION: rdata_nxt = `PCG_DIR_READ_VALUE;
                `PCG_OFS_LATCH:     rdata_nxt = output_latch_r;
                `PCG_OFS_VIEW:      rdata_nxt = pin_level_view;
                `PCG_OFS_PULLUP:    rdata_nxt = pullup_select_r;
                `PCG_OFS_OTYPE:     rdata_nxt = output_type_select_r;
                default:            rdata_nxt = `PCG_IDLE_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= `PCG_IDLE_READ_VALUE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

// >>> pcg_port_chk.sv
// Port-level assertions for the port C block
`timescale 1ns/1ps
`include "pcg_consts.svh"
module pcg_port_chk #(
    parameter int PORT_W = 8
) (
    input wire logic                   ref_clk,
    input wire logic                   nrst,
    input wire logic [`PCG_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_rd,
    input wire logic [PORT_W-1:0]      reg_rdata,
    input wire logic                   ch1_external_clock_select,
    input wire logic                   ch1_sync_mode,
    input wire logic                   ch1_clock_output_enable,
    input wire logic                   ch1_receive_enable,
    input wire logic                   ch1_transmit_enable,
    input wire logic                   serial_ch1_clock_out,
    input wire logic                   serial_ch1_transmit,
    input wire logic                   ch0_receive_enable,
    input wire logic                   ch0_transmit_enable,
    input wire logic                   serial_ch0_transmit,
    input wire logic                   external_interrupt_b,
    input wire logic [PORT_W-1:0]      pin_in,
    input wire logic [PORT_W-1:0]      pin_out,
    input wire logic [PORT_W-1:0]      pin_oe,
    input wire logic [PORT_W-1:0]      pin_pullup_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Cycles since reset release, saturating
    logic [1:0] up_r;
    logic [1:0] up_nxt;
    always_comb up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            up_r <= 2'h0;
        end else begin
            up_r <= up_nxt;
        end
    end
    dir_read_a: assert property (
        up_r != 2'h0 && $past(reg_rd && reg_addr == `PCG_OFS_DIRECTION) |-> reg_rdata == '0)
        else $error("Direction read not zero");
    pull_in_only_a: assert property ((pin_pullup_en & pin_oe) == '0)
        else $error("Pull-up on a driven pin");
    tx1_low_a: assert property (
        up_r != 2'h0 && $past(ch1_transmit_enable && !serial_ch1_transmit)
        |-> pin_oe[3] && !pin_out[3]) else $error("Channel one transmit low not driven");
    tx0_value_a: assert property (
        up_r != 2'h0 && $past(ch0_transmit_enable) && pin_oe[0]
        |-> pin_out[0] == $past(serial_ch0_transmit)) else $error("Channel zero transmit wrong");
    rx1_in_a: assert property (
        up_r != 2'h0 && $past(ch1_receive_enable) |-> !pin_oe[4] && !pin_pullup_en[4])
        else $error("Channel one receive pin not input");
    rx0_in_a: assert property (
        ch0_receive_enable [*2] |-> !pin_oe[1] && !pin_pullup_en[1])
        else $error("Channel zero receive pin not input");
    clk1_out_a: assert property (
        up_r != 2'h0 && $past(!ch1_external_clock_select && !serial_ch1_clock_out
        && (ch1_sync_mode || ch1_clock_output_enable)) |-> pin_oe[5] && !pin_out[5])
        else $error("Clock output not driven");
    clk1_in_a: assert property (
        up_r != 2'h0 && $past(ch1_external_clock_select) |-> !pin_oe[5] && !pin_pullup_en[5])
        else $error("Clock input pin driven or pulled");
    irq_sync_a: assert property (
        up_r == 2'h3 |-> external_interrupt_b == $past(pin_in[5], 3))
        else $error("Interrupt level not synchronised");
    cover property ($past(reg_rd) && reg_rdata != '0);
    cover property (ch1_external_clock_select && ch1_receive_enable == 1'b0);
    cover property (ch0_transmit_enable && pin_oe[0]);
endmodule

bind pcg_port pcg_port_chk #(.PORT_W(PORT_W)) chk_u (.*);

// >>> pcg_pads.sv
// Pad model resolving each pin from block drive, outside drive and pull-ups
`timescale 1ns/1ps
module pcg_pads (
    input  wire logic       ref_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup_en,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_in
);
    logic [7:0] float_r = 8'h55;
    // Undriven, unpulled pins wander every cycle
    always @(posedge ref_clk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pullup_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_r[i];
            end
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench for the port C block with a pad model
`timescale 1ns/1ps
`include "pcg_consts.svh"
module tb;
    logic                   ref_clk, nrst, reg_wr, reg_rd;
    logic [`PCG_ADDR_W-1:0] reg_addr;
    logic [7:0]             reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pin_pullup_en;
    logic [7:0]             ext_val, ext_en;
    logic                   ch1_external_clock_select, ch1_sync_mode, ch1_clock_output_enable;
    logic                   ch1_receive_enable, ch1_transmit_enable, serial_ch1_clock_out;
    logic                   serial_ch1_transmit, serial_ch1_clock_in, serial_ch1_receive;
    logic                   ch0_external_clock_select, ch0_sync_mode, ch0_clock_output_enable;
    logic                   ch0_receive_enable, ch0_transmit_enable, serial_ch0_clock_out;
    logic                   serial_ch0_transmit, serial_ch0_clock_in, serial_ch0_receive;
    logic                   external_interrupt_a, external_interrupt_b;
    int                     num_errors = 0;
    int                     checks_done = 0;
    pcg_port dut_u (.*);
    pcg_pads pads_u (.*);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic settle();
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task automatic per(input logic [4:0] c1, input logic [4:0] c0, input logic [7:0] en);
        @(posedge ref_clk);
        {ch1_external_clock_select, ch1_sync_mode, ch1_clock_output_enable,
            ch1_receive_enable, ch1_transmit_enable} <= c1;
        {ch0_external_clock_select, ch0_sync_mode, ch0_clock_output_enable,
            ch0_receive_enable, ch0_transmit_enable} <= c0;
        ext_en <= en;
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
    endtask
    task automatic t_reset();
        chk(pin_oe, 8'h00);
        chk(pin_pullup_en, 8'h00);
        rd_chk(`PCG_OFS_LATCH, 8'h00);
        rd_chk(`PCG_OFS_PULLUP, 8'h00);
        rd_chk(`PCG_OFS_OTYPE, 8'h00);
    endtask
    task automatic t_dir_view();
        per(5'h00, 5'h00, 8'hF0);
        ext_val <= 8'h60;
        wr(`PCG_OFS_LATCH, 8'hA5);
        wr(`PCG_OFS_DIRECTION, 8'h0F);
        settle();
        chk(pin_oe, 8'h0F);
        chk(pin_out & 8'h0F, 8'h05);
        rd_chk(`PCG_OFS_LATCH, 8'hA5);
        rd_chk(`PCG_OFS_DIRECTION, 8'h00);
        rd_chk(`PCG_OFS_VIEW, 8'h65);
        wr(`PCG_OFS_VIEW, 8'h9A);
        rd_chk(`PCG_OFS_VIEW, 8'h65);
        rd_chk(`PCG_OFS_LATCH, 8'hA5);
        @(posedge ref_clk);
        ext_val <= 8'h90;
        settle();
        rd_chk(`PCG_OFS_VIEW, 8'h95);
        rd_chk(3'h7, 8'h00);
    endtask
    task automatic t_pull_otype();
        per(5'h00, 5'h00, 8'h00);
        wr(`PCG_OFS_PULLUP, 8'hFF);
        wr(`PCG_OFS_OTYPE, 8'h03);
        wr(`PCG_OFS_LATCH, 8'h01);
        wr(`PCG_OFS_DIRECTION, 8'h43);
        settle();
        chk(pin_pullup_en, 8'hBC);
        chk(pin_oe & 8'h43, 8'h42);
        rd_chk(`PCG_OFS_VIEW, 8'hBD);
        wr(`PCG_OFS_OTYPE, 8'h00);
        settle();
        chk(pin_oe & 8'h43, 8'h43);
    endtask
    task automatic t_clk_modes();
        logic co;
        wr(`PCG_OFS_DIRECTION, 8'hC0);
        ext_val <= 8'h20;
        for (int m = 0; m < 8; m++) begin
            per({m[2:0], 2'b00}, {m[2:0], 2'b00}, {2'b00, m[2], 2'b00, m[2], 2'b00});
            settle();
            co = !m[2] && (m[1] || m[0]);
            chk(pin_oe, {2'b11, co, 2'b00, co, 2'b00});
            chk(pin_pullup_en, {2'b00, !m[2] && !co, 2'b11, !m[2] && !co, 2'b11});
            if (m[2]) begin
                chk({external_interrupt_b, external_interrupt_a, serial_ch1_clock_in,
                    serial_ch0_clock_in}, 8'h0A);
            end
        end
    endtask
    task automatic t_data();
        per(5'h03, 5'h03, 8'h12);
        ext_val <= 8'h10;
        serial_ch0_transmit <= 1'b1;
        settle();
        chk(pin_oe & 8'h1B, 8'h09);
        chk(pin_out & 8'h09, 8'h01);
        chk({serial_ch1_receive, serial_ch0_receive}, 8'h02);
        chk(pin_pullup_en & 8'h12, 8'h00);
        wr(`PCG_OFS_OTYPE, 8'h01);
        settle();
        chk(pin_oe & 8'h09, 8'h08);
        per(5'h00, 5'h00, 8'h00);
        settle();
        chk(pin_oe & 8'h1B, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 4000);
        num_errors++;
        report_and_stop();
    end
    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, ext_val, ext_en} = '0;
        {ch1_external_clock_select, ch1_sync_mode, ch1_clock_output_enable} = '0;
        {ch1_receive_enable, ch1_transmit_enable, serial_ch1_clock_out} = '0;
        {ch0_external_clock_select, ch0_sync_mode, ch0_clock_output_enable} = '0;
        {ch0_receive_enable, ch0_transmit_enable, serial_ch0_clock_out} = '0;
        {serial_ch1_transmit, serial_ch0_transmit} = '0;
        do_reset();
        t_reset();
        t_dir_view();
        t_pull_otype();
        t_clk_modes();
        t_data();
        settle();
        do_reset();
        t_reset();
        report_and_stop();
    end
endmodule
